// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top import tdce_pkg::*; ;
    logic        sys_clk = 1'b0, rst = 1'b1, rbl = 1'b1, rbf = 1'b0;
    logic        wv, wr, we, intr, blank;
    logic [15:0] wd, rbd, st, stc, last_rb, hd;
    logic [3:0]  rba = 4'h0, gpa;
    logic [7:0]  cp;
    logic [4:0]  ho;
    logic [6:0]  imask = 7'h00;
    logic [5:0]  pl = 6'h00;
    logic [31:0] lp;
    tdce_ctx_t   ctx = '0;
    tdce_evt_t   ev;
    int          seed = 95307, error_cnt = 0, checks = 0, cyc = 0, wcnt = 0, nsa = 0, npf = 0;
    initial forever #2 sys_clk = ~sys_clk;
    tdce_mem_model i_mem (.sys_clk(sys_clk), .word_ready(wr), .word_valid(wv), .word_data(wd));
    tdce_engine i_dut (.sys_clk(sys_clk), .rst(rst), .word_valid(wv), .word_data(wd), .word_ready(wr),
        .ctx(ctx), .proc_start(pl[4]), .frame_start(pl[0]), .row_swap(pl[1]), .rb_loaded(rbl),
        .phys_frame_end(pl[2]), .rb_full(rbf), .rb_attr(rba), .display_active_flag(1'b0),
        .virtual_display_active_flag(1'b0), .interrupt_mask(imask), .interrupt_clear_in(pl[5]),
        .status_read(pl[3]), .rb_we(we), .rb_data(rbd), .evt(ev), .cmd_param(cp), .list_pointer(lp),
        .list_pointer_load(), .hdr_wr(), .hdr_wr_ofs(ho), .hdr_wr_data(hd), .blank_screen(blank),
        .general_attribute_output(gpa), .status_word(st), .status_copy(stc), .host_interrupt_out(intr));
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (we === 1'b1) begin
            last_rb <= rbd;
            wcnt    <= wcnt + 1;
        end
        if (ev.next_string_action === 1'b1) nsa <= nsa + 1;
        if (ev.next_process_fetch === 1'b1) npf <= npf + 1;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    function automatic logic [3:0] gpa_exp(input logic [7:0] op, input logic [3:0] rb);
        for (int k = 0; k < 4; k++) gpa_exp[k] = op[2*k] ? op[2*k+1] : rb[k];
    endfunction : gpa_exp
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (e !== g) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic pulse(input int k);
        pl[k] <= 1'b1;
        @(posedge sys_clk);
        pl[k] <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask : pulse
    task automatic feed(input logic [15:0] w);
        i_mem.send(w);
        i_mem.idle();
        repeat (3) @(posedge sys_clk);
    endtask : feed
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        logic [15:0] m, d;
        logic [7:0]  op;
        logic [31:0] b0, b1;
        int          n;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("ready", 1, wr);
        chk("status", 0, st);
        d = 16'h7FFF & 16'($random(seed));
        feed(d);
        chk("rb_data", d, last_rb);
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 16'hFFFF : 16'($random(seed));
            d = 16'h7FFF & 16'($random(seed));
            n = wcnt;
            i_mem.send(16'h8E00);
            i_mem.send(m, i);
            i_mem.send(16'hC000 | (16'h3FFF & 16'($random(seed))));
            feed(d);
            chk("rb_data", d | m, last_rb);
            chk("writes", 1, wcnt - n);
        end
        pulse(0);
        feed(d);
        chk("rb_data", d, last_rb);
        for (int i = 0; i < 4; i++) begin
            op = (i == 0) ? 8'h55 : 8'($random(seed));
            rba <= 4'($random(seed));
            feed({8'h8D, op});
            chk("gpa", gpa_exp(op, rba), gpa);
            chk("hdr_ofs", 5'h0E, ho);
            chk("hdr_gpa", {8'h00, op}, hd);
            chk("param", op, cp);
        end
        pulse(0);
        imask <= 7'h7F;
        b0 = $random(seed);
        feed({8'h90 + 8'(b0[5:0] % 48), b0[15:8]});
        chk("rsv_flag", 1, st[6]);
        pulse(2);
        chk("fde_flag", 1, st[4]);
        chk("int_masked", 0, intr);
        imask <= 7'h00;
        pulse(2);
        chk("int_set", 1, intr);
        repeat (8) @(posedge sys_clk);
        chk("int_held", 1, intr);
        pulse(3);
        chk("copy", 16'h0050, stc);
        pulse(5);
        chk("int_clear", 0, intr);
        pulse(0);
        chk("flags", 0, st[6:0]);
        rbl <= 1'b0;
        pulse(1);
        chk("blank", 1, blank);
        chk("underrun", 1, st[0]);
        rbl <= 1'b1;
        pulse(2);
        chk("unblank", 0, blank);
        rbf <= 1'b1;
        feed(16'h0041);
        chk("overrun", 1, st[3]);
        rbf <= 1'b0;
        d = 16'h7FFF & 16'($random(seed));
        n = wcnt;
        i_mem.send(16'h8A03);
        feed(d);
        repeat (4) @(posedge sys_clk);
        chk("repeat_writes", 3, wcnt - n);
        chk("rb_data", d, last_rb);
        n = wcnt;
        i_mem.send(16'h8902);
        i_mem.send(16'h8A03);
        feed(d);
        repeat (4) @(posedge sys_clk);
        chk("skip_repeat_writes", 1, wcnt - n);
        n = wcnt;
        i_mem.send(16'h8905);
        i_mem.send(16'h8100);
        feed(d);
        chk("skip_end_writes", 1, wcnt - n);
        n = nsa;
        i_mem.send(16'h8702);
        i_mem.send(d);
        feed(d);
        chk("limit_string_end", 1, nsa - n);
        b0 = $random(seed);
        b1 = $random(seed);
        n  = $random(seed) & 1;
        ctx <= '{cmd_proc: 1'b1, list_select_bit: n[0], list_base_zero: b0, list_base_one: b1, default: '0};
        pulse(4);
        feed(16'h8F00);
        chk("list_ptr", n[0] ? b1 : b0, lp);
        n = npf;
        feed(16'hC000 | (16'h3FFF & 16'($random(seed))));
        chk("nop_next_proc", 1, npf - n);
        n = npf;
        feed(16'h8000);
        chk("row_end_wait", 0, npf - n);
        pulse(1);
        chk("row_end_next_proc", 1, npf - n);
        report_and_stop();
    end
endmodule : tb_top

// ===== dv/tdce_mem_model.sv
`timescale 1ns/1ns
module tdce_mem_model (
    // Clock
    input  wire logic   sys_clk,
    // Word stream
    input  wire logic   word_ready,
    output logic        word_valid,
    output logic [15:0] word_data
);
    logic [15:0] last_q = 16'h0000;
    initial begin
        word_valid = 1'b0;
        word_data  = 16'h0000;
    end
    // Offers a word and holds it until the edge that takes it
    task automatic send(input logic [15:0] w, input int gap = 0);
        if (gap > 0) begin
            word_valid <= 1'b0;
            word_data  <= ~last_q;
            repeat (gap) @(posedge sys_clk);
        end
        word_valid <= 1'b1;
        word_data  <= w;
        last_q     = w;
        do @(posedge sys_clk); while (word_ready !== 1'b1);
    endtask : send
    // Released bus shows the inverse of the last word
    task automatic idle();
        word_valid <= 1'b0;
        word_data  <= ~last_q;
        @(posedge sys_clk);
    endtask : idle
endmodule : tdce_mem_model

// ===== verilog/tdce_cfg.svh
`ifndef TDCE_CFG_SVH
`define TDCE_CFG_SVH
`define TDCE_CMD_BIT        15
`define TDCE_NOP_BIT        14
`define TDCE_OP_ROW_END     8'h80
`define TDCE_OP_FRAME_END   8'h81
`define TDCE_OP_LINE_END    8'h82
`define TDCE_OP_FULL_ROW    8'h83
`define TDCE_OP_SCROLL_BEG  8'h84
`define TDCE_OP_SCROLL_FIN  8'h85
`define TDCE_OP_TAB         8'h86
`define TDCE_OP_LIMIT       8'h87
`define TDCE_OP_NEXT_STR    8'h88
`define TDCE_OP_SKIP        8'h89
`define TDCE_OP_REPEAT      8'h8A
`define TDCE_OP_SCRIPT      8'h8B
`define TDCE_OP_RPT_PAIR    8'h8C
`define TDCE_OP_GPA         8'h8D
`define TDCE_OP_MASK        8'h8E
`define TDCE_OP_WINDOW      8'h8F
`define TDCE_OP_RSV_LO      8'h90
`define TDCE_ST_DUR         0
`define TDCE_ST_BUFFER_OVERRUN_FLAG        3
`define TDCE_ST_FDE         4
`define TDCE_ST_RDC         6
`define TDCE_INT_W          7
`define TDCE_HDR_LIMIT_OFS  5'h04
`define TDCE_HDR_GPA_OFS    5'h0E
`define TDCE_HDR_MASK_OFS   5'h10
`define TDCE_HDR_LIST_POINTER_OFS   5'h12
`define TDCE_CNT_LAST       9'h001
`define TDCE_CNT_RESET      9'h100
`define TDCE_N_ONE          8'h01
`define TDCE_GPA_N          4
`endif

// ===== verilog/tdce_engine.sv
`timescale 1ns/1ns
`include "tdce_cfg.svh"
module tdce_engine import tdce_pkg::*; (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Fetched datastream words
    input  wire logic        word_valid,
    input  wire logic [15:0] word_data,
    output logic             word_ready,
    // Process context
    input  wire tdce_ctx_t   ctx,
    input  wire logic        proc_start,
    // Display generator
    input  wire logic        frame_start,
    input  wire logic        row_swap,
    input  wire logic        rb_loaded,
    input  wire logic        phys_frame_end,
    input  wire logic        rb_full,
    input  wire logic [3:0]  rb_attr,
    input  wire logic        display_active_flag,
    input  wire logic        virtual_display_active_flag,
    // Host side
    input  wire logic [6:0]  interrupt_mask,
    input  wire logic        interrupt_clear_in,
    input  wire logic        status_read,
    // Row buffer write
    output logic             rb_we,
    output logic [15:0]      rb_data,
    // Actions and parameters
    output tdce_evt_t        evt,
    output logic [7:0]       cmd_param,
    output logic [31:0]      list_pointer,
    output logic             list_pointer_load,
    output logic             hdr_wr,
    output logic [4:0]       hdr_wr_ofs,
    output logic [15:0]      hdr_wr_data,
    output logic             blank_screen,
    output logic [3:0]       general_attribute_output,
    // Status
    output logic [15:0]      status_word,
    output logic [15:0]      status_copy,
    output logic             host_interrupt_out
);
    tdce_state_t state_q, state_d;
    tdce_evt_t   ev_d, force_d;
    logic [15:0] mask_q, wdat;
    logic [15:0] ch0_q, ch1_q;
    logic [7:0]  n_q, lim_q, gpa_q, op, par;
    logic [8:0]  cnt_q;
    logic [9:0]  skip_q;
    logic        ph_q, pair_q, ovr_q, eof_seen_q, wait_q, clr_s1_q, clr_s2_q;
    logic [6:0]  st_q, st_set;
    logic        take, wr, cnt_dec, skip_dec, reserved_code_flag, ld_lim, lp_ld, gpa_ld, mask_ld;
    logic        fe_cmd, skip_add, skip_clr, lim_hit, buffer_overrun_flag, n_ld, n_dec, ph_tgl;
    logic        dur_ev, fde_ev;

    assign take = word_valid && word_ready;
    assign op   = word_data[15:8];
    assign par  = word_data[7:0];

    // Decode and sequencing of the word stream
    always_comb begin
        ev_d = '0;
        state_d = state_q;
        wr = 1'b0;
        wdat = word_data | mask_q;
        cnt_dec = 1'b0;
        skip_dec = 1'b0;
        reserved_code_flag = 1'b0;
        ld_lim = 1'b0;
        lp_ld = 1'b0;
        gpa_ld = 1'b0;
        mask_ld = 1'b0;
        fe_cmd = 1'b0;
        skip_add = 1'b0;
        skip_clr = 1'b0;
        n_ld = 1'b0;
        n_dec = 1'b0;
        ph_tgl = 1'b0;
        buffer_overrun_flag = 1'b0;
        case (state_q)
            S_CMD: if (take) begin
                if (!word_data[`TDCE_CMD_BIT]) begin
                    if (skip_q != '0) skip_dec = 1'b1;
                    else begin
                        wr = 1'b1;
                        cnt_dec = 1'b1;
                    end
                end else if (word_data[`TDCE_NOP_BIT]) begin
                    ev_d.next_process_fetch = ctx.cmd_proc;
                end else if (op >= `TDCE_OP_RSV_LO) begin
                    reserved_code_flag = 1'b1;
                    ev_d.next_process_fetch = ctx.cmd_proc;
                end else if (ctx.cmd_proc) begin
                    ev_d.next_process_fetch = 1'b1;
                    if (op == `TDCE_OP_ROW_END) begin
                        ev_d.row_end_command = 1'b1;
                        ev_d.next_process_fetch = 1'b0;
                    end else if (op == `TDCE_OP_FRAME_END) begin
                        ev_d.frame_end = 1'b1;
                        fe_cmd = 1'b1;
                    end else if (op == `TDCE_OP_LINE_END) ev_d.next_string_action = 1'b1;
                    else if (op == `TDCE_OP_FULL_ROW) ev_d.full_row_descriptor = 1'b1;
                    else if (op == `TDCE_OP_SCROLL_BEG) ev_d.slow_scroll_begin = 1'b1;
                    else if (op == `TDCE_OP_SCROLL_FIN) ev_d.slow_scroll_finish = 1'b1;
                    else if (op == `TDCE_OP_TAB) ev_d.column_tab = 1'b1;
                    else if (op == `TDCE_OP_LIMIT) ld_lim = 1'b1;
                    else if (op == `TDCE_OP_WINDOW) begin
                        lp_ld = 1'b1;
                        ev_d.end_of_display_clear = 1'b1;
                    end
                end else if (ctx.virtual_mode && op <= `TDCE_OP_LINE_END) begin
                    ev_d.virtual_row_end = 1'b1;
                    ev_d.next_string_action = (op == `TDCE_OP_LINE_END);
                end else if (op == `TDCE_OP_ROW_END) begin
                    ev_d.row_end_command = 1'b1;
                    skip_clr = !ctx.auto_line_feed_flag;
                end else if (op == `TDCE_OP_FRAME_END) begin
                    ev_d.frame_end = 1'b1;
                    fe_cmd = 1'b1;
                    skip_clr = 1'b1;
                end else if (op == `TDCE_OP_LINE_END) begin
                    ev_d.next_string_action = 1'b1;
                    ev_d.row_end_command = !ctx.auto_line_feed_flag;
                end else if (op <= `TDCE_OP_LIMIT) begin
                    if (!ctx.virtual_mode) begin
                        ev_d.full_row_descriptor = (op == `TDCE_OP_FULL_ROW);
                        ev_d.slow_scroll_begin = (op == `TDCE_OP_SCROLL_BEG);
                        ev_d.slow_scroll_finish = (op == `TDCE_OP_SCROLL_FIN);
                        ev_d.column_tab = (op == `TDCE_OP_TAB) && (skip_q == '0);
                        ld_lim = (op == `TDCE_OP_LIMIT);
                    end
                end else if (op == `TDCE_OP_NEXT_STR) ev_d.next_string_action = 1'b1;
                else if (op == `TDCE_OP_SKIP) skip_add = 1'b1;
                else if (op == `TDCE_OP_REPEAT || op == `TDCE_OP_RPT_PAIR) begin
                    n_ld = 1'b1;
                    state_d = S_RCH;
                end else if (op == `TDCE_OP_SCRIPT) begin
                    n_ld = 1'b1;
                    if (par != '0) state_d = S_SS;
                end else if (op == `TDCE_OP_GPA) begin
                    if (skip_q == '0) begin
                        gpa_ld = 1'b1;
                        cnt_dec = 1'b1;
                    end
                end else if (op == `TDCE_OP_MASK) state_d = S_MASK;
            end
            S_MASK: if (take) begin
                mask_ld = 1'b1;
                state_d = S_CMD;
            end
            S_RCH: if (take) begin
                ph_tgl = pair_q;
                if (!pair_q || ph_q) state_d = (n_q == '0) ? S_CMD : S_EMIT;
            end
            S_EMIT: begin
                wdat = (ph_q ? ch1_q : ch0_q) | mask_q;
                ph_tgl = pair_q;
                if (!pair_q || ph_q) begin
                    n_dec = 1'b1;
                    if (skip_q != '0) skip_dec = 1'b1;
                    else cnt_dec = 1'b1;
                    if (n_q == `TDCE_N_ONE) state_d = S_CMD;
                end
                wr = (skip_q == '0);
            end
            S_SS: if (take) begin
                ph_tgl = 1'b1;
                wr = (skip_q == '0);
                if (ph_q) begin
                    n_dec = 1'b1;
                    if (skip_q != '0) skip_dec = 1'b1;
                    else cnt_dec = 1'b1;
                    if (n_q == `TDCE_N_ONE) state_d = S_CMD;
                end
            end
            default: state_d = S_CMD;
        endcase
        if (wr && rb_full) begin
            wr = 1'b0;
            cnt_dec = 1'b0;
            buffer_overrun_flag = 1'b1;
            if (state_q == S_EMIT) state_d = S_CMD;
        end
        lim_hit = cnt_dec && (cnt_q == `TDCE_CNT_LAST);
        if (lim_hit) begin
            if (ctx.virtual_mode) ev_d.virtual_row_end = 1'b1;
            else ev_d.row_end_command = 1'b1;
            if (!ctx.auto_line_feed_flag) begin
                ev_d.next_string_action = 1'b1;
                state_d = S_CMD;
            end
        end
    end

    assign dur_ev = row_swap && !rb_loaded;
    assign fde_ev = phys_frame_end && !eof_seen_q && !fe_cmd;
    always_comb begin
        force_d = '0;
        force_d.frame_end = dur_ev || fde_ev;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= S_CMD;
            word_ready <= 1'b0;
            n_q <= '0;
            ph_q <= 1'b0;
            pair_q <= 1'b0;
        end else begin
            state_q <= state_d;
            word_ready <= (state_d != S_EMIT);
            if (n_ld) begin
                n_q <= par;
                pair_q <= (op != `TDCE_OP_REPEAT);
            end else if (n_dec) begin
                n_q <= n_q - `TDCE_N_ONE;
            end
            if (state_d == S_CMD || n_ld) ph_q <= 1'b0;
            else if (ph_tgl) ph_q <= !ph_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ch0_q <= '0;
            ch1_q <= '0;
        end else if (state_q == S_RCH && take) begin
            if (ph_q) ch1_q <= word_data;
            else ch0_q <= word_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            skip_q <= '0;
        end else if (skip_clr) begin
            skip_q <= '0;
        end else if (skip_add) begin
            skip_q <= skip_q - {9'h000, skip_dec} + {2'h0, par};
        end else if (skip_dec) begin
            skip_q <= skip_q - 10'h001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_q <= '0;
        end else if (frame_start) begin
            mask_q <= '0;
        end else if (mask_ld) begin
            mask_q <= word_data;
        end else if (proc_start && ctx.virtual_mode) begin
            mask_q <= ctx.field_mask;
        end
    end

    // Fetch limit register and counter, zero meaning 256
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lim_q <= '0;
            cnt_q <= `TDCE_CNT_RESET;
            ovr_q <= 1'b0;
        end else if (ld_lim) begin
            lim_q <= par;
            cnt_q <= {par == '0, par};
            ovr_q <= ctx.cmd_proc;
        end else if (proc_start) begin
            ovr_q <= 1'b0;
            if (!ovr_q) begin
                lim_q <= ctx.fetch_limit;
                cnt_q <= {ctx.fetch_limit == '0, ctx.fetch_limit};
            end
        end else if (lim_hit) begin
            cnt_q <= {lim_q == '0, lim_q};
        end else if (cnt_dec) begin
            cnt_q <= cnt_q - `TDCE_CNT_LAST;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rb_we <= 1'b0;
            rb_data <= '0;
            evt <= '0;
            cmd_param <= '0;
            hdr_wr <= 1'b0;
            hdr_wr_ofs <= '0;
            hdr_wr_data <= '0;
            list_pointer <= '0;
            list_pointer_load <= 1'b0;
            gpa_q <= '0;
            wait_q <= 1'b0;
        end else begin
            rb_we <= wr;
            if (wr) rb_data <= wdat;
            evt <= ev_d | force_d;
            evt.next_process_fetch <= ev_d.next_process_fetch || (wait_q && row_swap);
            if (ev_d.row_end_command && ctx.cmd_proc && !lim_hit) wait_q <= 1'b1;
            else if (row_swap) wait_q <= 1'b0;
            if (take) cmd_param <= par;
            list_pointer_load <= lp_ld;
            if (lp_ld) list_pointer <= ctx.list_select_bit ? ctx.list_base_one : ctx.list_base_zero;
            if (gpa_ld) gpa_q <= par;
            hdr_wr <= ev_d.virtual_row_end || gpa_ld;
            if (ev_d.virtual_row_end) begin
                hdr_wr_ofs <= `TDCE_HDR_LIMIT_OFS;
                hdr_wr_data <= {8'h00, lim_q};
            end else if (gpa_ld) begin
                hdr_wr_ofs <= `TDCE_HDR_GPA_OFS;
                hdr_wr_data <= {8'h00, par};
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `TDCE_GPA_N; gi++) begin : g_gpa
            tdce_gpa_bit u_gpa (
                .sys_clk (sys_clk),
                .rst     (rst),
                .enable  (gpa_q[2*gi]),
                .level   (gpa_q[2*gi+1]),
                .rb_bit  (rb_attr[gi]),
                .attr_q  (general_attribute_output[gi])
            );
        end
    endgenerate

    // Errors, status and interrupt
    always_comb begin
        st_set = '0;
        st_set[`TDCE_ST_DUR] = dur_ev;
        st_set[`TDCE_ST_BUFFER_OVERRUN_FLAG] = buffer_overrun_flag;
        st_set[`TDCE_ST_FDE] = fde_ev;
        st_set[`TDCE_ST_RDC] = reserved_code_flag;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clr_s1_q <= 1'b0;
            clr_s2_q <= 1'b0;
            eof_seen_q <= 1'b0;
            blank_screen <= 1'b0;
            st_q <= '0;
            status_word <= '0;
            status_copy <= '0;
            host_interrupt_out <= 1'b0;
        end else begin
            clr_s1_q <= interrupt_clear_in;
            clr_s2_q <= clr_s1_q;
            if (fe_cmd) eof_seen_q <= 1'b1;
            else if (frame_start) eof_seen_q <= 1'b0;
            if (dur_ev) blank_screen <= 1'b1;
            else if (phys_frame_end) blank_screen <= 1'b0;
            st_q <= st_set | (frame_start ? '0 : st_q);
            status_word <= {7'h00, virtual_display_active_flag, display_active_flag, st_set | st_q};
            if (status_read) status_copy <= {7'h00, virtual_display_active_flag, display_active_flag, st_q};
            if (phys_frame_end && |((st_q | st_set) & ~interrupt_mask)) host_interrupt_out <= 1'b1;
            else if (clr_s2_q) host_interrupt_out <= 1'b0;
        end
    end

    property p_mask_apply;
        @(posedge sys_clk) disable iff (rst) wr |=> ((rb_data & $past(mask_q)) == $past(mask_q));
    endproperty
    a_mask_apply: assert property (p_mask_apply) else $error("mask bits not forced");
    property p_mask_frame;
        @(posedge sys_clk) disable iff (rst) frame_start |=> mask_q == '0;
    endproperty
    a_mask_frame: assert property (p_mask_frame) else $error("mask not cleared at frame");
    property p_nop_proc;
        @(posedge sys_clk) disable iff (rst)
            (state_q == S_CMD && take && word_data[15:14] == 2'h3 && ctx.cmd_proc) |=> evt.next_process_fetch;
    endproperty
    a_nop_proc: assert property (p_nop_proc) else $error("process nop did not advance");
    property p_gpa;
        @(posedge sys_clk) disable iff (rst) gpa_q[0] |=> general_attribute_output[0] == $past(gpa_q[1]);
    endproperty
    a_gpa: assert property (p_gpa) else $error("attribute output wrong");
    property p_limit;
        @(posedge sys_clk) disable iff (rst)
            (lim_hit && !ctx.auto_line_feed_flag) |=> evt.next_string_action && state_q == S_CMD;
    endproperty
    a_limit: assert property (p_limit) else $error("limit did not end string");
    property p_skip_fe;
        @(posedge sys_clk) disable iff (rst) skip_clr |=> skip_q == '0;
    endproperty
    a_skip_fe: assert property (p_skip_fe) else $error("skip not stopped");
    property p_rdc;
        @(posedge sys_clk) disable iff (rst) reserved_code_flag && !frame_start |=> status_word[`TDCE_ST_RDC] && st_q[`TDCE_ST_RDC];
    endproperty
    a_rdc: assert property (p_rdc) else $error("reserved code not flagged");
    property p_window;
        @(posedge sys_clk) disable iff (rst) lp_ld |=> list_pointer_load && evt.end_of_display_clear;
    endproperty
    a_window: assert property (p_window) else $error("window command incomplete");
    property p_underrun;
        @(posedge sys_clk) disable iff (rst) dur_ev |=> blank_screen && evt.frame_end && status_word[`TDCE_ST_DUR];
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not handled");
    property p_fde;
        @(posedge sys_clk) disable iff (rst) fde_ev |=> evt.frame_end && status_word[`TDCE_ST_FDE];
    endproperty
    a_fde: assert property (p_fde) else $error("frame data error missed");
    property p_int_hold;
        @(posedge sys_clk) disable iff (rst) (host_interrupt_out && !clr_s2_q) |=> host_interrupt_out;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
    c_emit: cover property (@(posedge sys_clk) disable iff (rst) state_q == S_EMIT ##1 state_q == S_CMD);
    c_skip_rep: cover property (@(posedge sys_clk) disable iff (rst) state_q == S_EMIT && skip_q != '0);
    c_int: cover property (@(posedge sys_clk) disable iff (rst) $rose(host_interrupt_out));
endmodule : tdce_engine

// ===== verilog/tdce_gpa_bit.sv
`timescale 1ns/1ns
module tdce_gpa_bit (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Operand bits and row buffer bit
    input  wire logic enable,
    input  wire logic level,
    input  wire logic rb_bit,
    // Attribute pin
    output logic      attr_q
);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            attr_q <= 1'b0;
        end else begin
            attr_q <= enable ? level : rb_bit;
        end
    end
endmodule : tdce_gpa_bit

// ===== verilog/tdce_pkg.sv
`include "tdce_cfg.svh"
package tdce_pkg;
    typedef enum logic [2:0] {S_CMD, S_MASK, S_RCH, S_EMIT, S_SS} tdce_state_t;
    typedef struct packed {
        logic        cmd_proc;
        logic        virtual_mode;
        logic        auto_line_feed_flag;
        logic        list_select_bit;
        logic [31:0] list_base_zero;
        logic [31:0] list_base_one;
        logic [7:0]  fetch_limit;
        logic [15:0] field_mask;
    } tdce_ctx_t;
    typedef struct packed {
        logic row_end_command;
        logic frame_end;
        logic virtual_row_end;
        logic next_string_action;
        logic full_row_descriptor;
        logic slow_scroll_begin;
        logic slow_scroll_finish;
        logic column_tab;
        logic next_process_fetch;
        logic end_of_display_clear;
    } tdce_evt_t;
endpackage : tdce_pkg
